// ===== common/rcs_pkg.sv
package rcs_pkg;

  // ---------------------------------------------------------------------
  // Register map (byte addresses, one aligned 32-bit word each)
  // ---------------------------------------------------------------------
  localparam logic [3:0] RCS_CTRL_ADDR    = 4'h0;
  localparam logic [3:0] RCS_STATUS_ADDR  = 4'h4;
  localparam logic [3:0] RCS_WDT_CLR_ADDR = 4'h8;

  // ---------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------
  localparam int RCS_CTRL_PIN_OPT_BIT   = 0;
  localparam int RCS_CTRL_CLK_MODE_BIT  = 1;
  localparam int RCS_CTRL_NDIV_LSB      = 2;
  localparam int RCS_CTRL_SDIV_LSB      = 5;
  localparam int RCS_CTRL_FOSC_LSB      = 8;

  // Reset values of the control fields.
  localparam logic       RCS_PIN_OPT_RST  = 1'b1;
  localparam logic       RCS_CLK_MODE_RST = 1'b0;
  localparam logic [2:0] RCS_NDIV_RST     = 3'h0;
  localparam logic [1:0] RCS_SDIV_RST     = 2'h0;
  localparam logic [2:0] RCS_FOSC_RST     = 3'h0;

  // ---------------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------------
  localparam int RCS_STAT_STATE_LSB     = 0;
  localparam int RCS_STAT_CAUSE_PIN_BIT = 2;
  localparam int RCS_STAT_CAUSE_WDT_BIT = 3;
  localparam int RCS_STAT_PGOOD_BIT     = 4;
  localparam int RCS_STAT_SLOW_BIT      = 5;

  // ---------------------------------------------------------------------
  // Fast oscillator choices (fast_oscillator_option)
  // ---------------------------------------------------------------------
  localparam logic [2:0] RCS_FOSC_INT_16M  = 3'h0;
  localparam logic [2:0] RCS_FOSC_INT_RTC  = 3'h1;
  localparam logic [2:0] RCS_FOSC_EXT_4M   = 3'h2;
  localparam logic [2:0] RCS_FOSC_EXT_12M  = 3'h3;
  localparam logic [2:0] RCS_FOSC_EXT_32K  = 3'h4;
  localparam logic [2:0] RCS_FOSC_EXT_RC   = 3'h5;
  localparam int         RCS_FOSC_NUM      = 6;

  // ---------------------------------------------------------------------
  // Counts
  // ---------------------------------------------------------------------
  localparam int RCS_WARMUP_CYCLES = 2048;
  localparam int RCS_WDT_TICKS     = 1024;
  localparam int RCS_PC_W          = 12;
  localparam logic [RCS_PC_W-1:0] RCS_RESET_VECTOR = 12'h000;

endpackage : rcs_pkg

// ===== hdl/rcs_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - Reset pin acts only when option enabled.
// - Reset pin low holds reset, high runs.
// - Pin resets at power-up and while running.
// - First step waits until pin is high.
// - Initialize system registers after pin release.
// - Warm up oscillator, then deliver clock.
// - Execution starts from program address zero.
// - Uncleared watchdog overflow forces full reset.
// - Watchdog reset runs normal sequence again.
// - Supply bad blocks reset release; run ignores it.
// - Fast source chosen by configuration option.
// - Slow source internal RC, mode bit selects.
// - Selected source passes through rate divider.
// - Normal mode divides fast source 1..128.
// - Slow mode divides slow source 1..8.
// - Mode bit zero normal, one slow.
module rcs_sequencer
  import rcs_pkg::*;
#(
  parameter int WARMUP_CYCLES = rcs_pkg::RCS_WARMUP_CYCLES,
  parameter int WDT_TICKS     = rcs_pkg::RCS_WDT_TICKS
)(
  input  wire logic                         clk_i,           // 100 MHz
  input  wire logic                         rst_n_i,         // Power-on
  input  wire logic                         rst_pin_n_i,     // Ext reset
  input  wire logic                         power_good_i,    // Supply ok
  input  wire logic [rcs_pkg::RCS_FOSC_NUM-1:0] fast_tick_i, // Fast srcs
  input  wire logic                         slow_tick_i,     // Slow RC
  input  wire logic [3:0]                   avs_address,     // Byte addr
  input  wire logic                         avs_read,        // Read
  input  wire logic                         avs_write,       // Write
  input  wire logic [31:0]                  avs_writedata,   // Wr data
  input  wire logic [3:0]                   avs_byteenable,  // Lanes
  output logic [31:0]                       avs_readdata,    // Rd data
  output logic                              avs_waitrequest, // Stall
  output logic                              sys_rst_n_o,     // Core rst
  output logic                              sys_init_o,      // Init pulse
  output logic                              core_clk_en_o,   // Clock on
  output logic                              exec_start_o,    // Start
  output logic [rcs_pkg::RCS_PC_W-1:0]      start_addr_o,    // Vector
  output logic                              cpu_tick_o       // Instr tick
);

  // -----------------------------------------------------------------------
  // Types and declarations
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_WAIT_PIN,
    ST_INIT,
    ST_WARMUP,
    ST_RUN
  } rcs_state_e;

  rcs_state_e  state;
  rcs_state_e  next_state;
  logic        pin_meta;
  logic        pin_sync;
  logic        pin_reset;
  logic        wdt_overflow;
  logic [15:0] warm_cnt;
  logic [15:0] wdt_cnt;
  logic [6:0]  div_cnt;
  logic [6:0]  div_last;
  logic        src_tick;
  logic        mode_q;
  logic        ack;
  logic        wr_fire;
  logic [31:0] rd_value;
  logic        reset_pin_option;
  logic        clock_mode_select;
  logic [2:0]  normal_divider_option;
  logic [1:0]  slow_divider_option;
  logic [2:0]  fast_oscillator_option;
  logic        cause_pin;
  logic        cause_wdt;

  localparam logic [15:0] WARM_LAST = 16'(WARMUP_CYCLES - 1);
  localparam logic [15:0] WDT_LAST  = 16'(WDT_TICKS - 1);

  // -----------------------------------------------------------------------
  // Reset pin synchroniser
  // -----------------------------------------------------------------------
  // two-stage synchroniser
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= rst_pin_n_i;
      pin_sync <= pin_meta;
    end
  end

  assign pin_reset = reset_pin_option & ~pin_sync;

  // -----------------------------------------------------------------------
  // Reset sequencer
  // -----------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_WAIT_PIN:
      begin
        if (!pin_reset && power_good_i)
        begin
          next_state = ST_INIT;
        end
      end
      ST_INIT:
      begin
        next_state = ST_WARMUP;
      end
      ST_WARMUP:
      begin
        if (warm_cnt == WARM_LAST)
        begin
          next_state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        next_state = ST_RUN;
      end
      default:
      begin
        next_state = ST_WAIT_PIN;
      end
    endcase
    if (pin_reset || wdt_overflow)
    begin
      next_state = ST_WAIT_PIN;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= ST_WAIT_PIN;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      warm_cnt <= 16'h0000;
    end
    else if (state == ST_WARMUP)
    begin
      warm_cnt <= warm_cnt + 16'h0001;
    end
    else
    begin
      warm_cnt <= 16'h0000;
    end
  end

  // Reset causes stay until the next power-on reset so software can see
  // why it restarted.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cause_pin <= 1'b0;
      cause_wdt <= 1'b0;
    end
    else
    begin
      // Only a pin reset that cuts a running sequence counts, so the
      // synchroniser's power-on value does not mark every start-up.
      if (pin_reset && state != ST_WAIT_PIN)
      begin
        cause_pin <= 1'b1;
      end
      if (wdt_overflow)
      begin
        cause_wdt <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Sequencer outputs
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sys_init_o    <= 1'b0;
      core_clk_en_o <= 1'b0;
      exec_start_o  <= 1'b0;
      start_addr_o  <= RCS_RESET_VECTOR;
    end
    else
    begin
      sys_init_o    <= (state == ST_INIT);
      core_clk_en_o <= (next_state == ST_RUN);
      exec_start_o  <= (state == ST_WARMUP) && (next_state == ST_RUN);
      if (state == ST_INIT)
      begin
        start_addr_o <= RCS_RESET_VECTOR;
      end
    end
  end

  // The raw pin also forces reset combinationally, so the core is held
  // even while the clock or the synchroniser is not yet running.
  // asynchronous assertion
  assign sys_rst_n_o = core_clk_en_o & ~(reset_pin_option & ~rst_pin_n_i);

  // -----------------------------------------------------------------------
  // Watchdog
  // -----------------------------------------------------------------------
  assign wdt_overflow = (state == ST_RUN) && slow_tick_i
                        && (wdt_cnt == WDT_LAST) && !wr_fire_clr();

  function automatic logic wr_fire_clr();
    return wr_fire && (avs_address == RCS_WDT_CLR_ADDR)
           && avs_byteenable[0] && avs_writedata[0];
  endfunction : wr_fire_clr

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wdt_cnt <= 16'h0000;
    end
    else if (state != ST_RUN || wr_fire_clr() || wdt_overflow)
    begin
      wdt_cnt <= 16'h0000;
    end
    else if (slow_tick_i)
    begin
      wdt_cnt <= wdt_cnt + 16'h0001;
    end
  end

  // -----------------------------------------------------------------------
  // Instruction rate divider
  // -----------------------------------------------------------------------
  always_comb
  begin
    if (clock_mode_select)
    begin
      src_tick = slow_tick_i;
      div_last = 7'((8'h01 << slow_divider_option) - 8'h01);
    end
    else
    begin
      src_tick = (fast_oscillator_option < 3'(RCS_FOSC_NUM))
                 ? fast_tick_i[fast_oscillator_option] : 1'b0;
      div_last = 7'((8'h01 << normal_divider_option) - 8'h01);
    end
  end

  // A mode change restarts the divider so no short instruction cycle is
  // built from ticks of two different sources.
  // divide selected source
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_cnt    <= 7'h00;
      cpu_tick_o <= 1'b0;
      mode_q     <= RCS_CLK_MODE_RST;
    end
    else
    begin
      mode_q     <= clock_mode_select;
      cpu_tick_o <= 1'b0;
      if (state != ST_RUN || mode_q != clock_mode_select)
      begin
        div_cnt <= 7'h00;
      end
      else if (src_tick)
      begin
        if (div_cnt >= div_last)
        begin
          div_cnt    <= 7'h00;
          cpu_tick_o <= 1'b1;
        end
        else
        begin
          div_cnt <= div_cnt + 7'h01;
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then the answer
  // -----------------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_fire         = avs_write & ack;

  always_comb
  begin
    rd_value = 32'h0000_0000;
    case (avs_address)
      RCS_CTRL_ADDR:
      begin
        rd_value[RCS_CTRL_PIN_OPT_BIT]  = reset_pin_option;
        rd_value[RCS_CTRL_CLK_MODE_BIT] = clock_mode_select;
        rd_value[RCS_CTRL_NDIV_LSB +: 3] = normal_divider_option;
        rd_value[RCS_CTRL_SDIV_LSB +: 2] = slow_divider_option;
        rd_value[RCS_CTRL_FOSC_LSB +: 3] = fast_oscillator_option;
      end
      RCS_STATUS_ADDR:
      begin
        rd_value[RCS_STAT_STATE_LSB +: 2]  = state;
        rd_value[RCS_STAT_CAUSE_PIN_BIT]   = cause_pin;
        rd_value[RCS_STAT_CAUSE_WDT_BIT]   = cause_wdt;
        rd_value[RCS_STAT_PGOOD_BIT]       = power_good_i;
        rd_value[RCS_STAT_SLOW_BIT]        = clock_mode_select;
      end
      default:
      begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ack          <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack <= (avs_read | avs_write) & ~ack;
      if (avs_read && !ack)
      begin
        avs_readdata <= rd_value;
      end
    end
  end

  // Configuration survives watchdog and pin resets; only power-on
  // clears it, as option bits would in a real part.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reset_pin_option       <= RCS_PIN_OPT_RST;
      clock_mode_select      <= RCS_CLK_MODE_RST;
      normal_divider_option  <= RCS_NDIV_RST;
      slow_divider_option    <= RCS_SDIV_RST;
      fast_oscillator_option <= RCS_FOSC_RST;
    end
    else if (wr_fire && avs_address == RCS_CTRL_ADDR)
    begin
      if (avs_byteenable[0])
      begin
        reset_pin_option      <= avs_writedata[RCS_CTRL_PIN_OPT_BIT];
        clock_mode_select     <= avs_writedata[RCS_CTRL_CLK_MODE_BIT];
        normal_divider_option <= avs_writedata[RCS_CTRL_NDIV_LSB +: 3];
        slow_divider_option   <= avs_writedata[RCS_CTRL_SDIV_LSB +: 2];
      end
      if (avs_byteenable[1])
      begin
        fast_oscillator_option <= avs_writedata[RCS_CTRL_FOSC_LSB +: 3];
      end
    end
  end

endmodule : rcs_sequencer

// ===== verif/rcs_sequencer_assertions.sv
`timescale 1ns/1ps
module rcs_checker
  import rcs_pkg::*;
#(
  parameter int WARMUP_CYCLES = RCS_WARMUP_CYCLES,
  parameter int WDT_TICKS     = RCS_WDT_TICKS
)(
  input wire logic                             clk_i,           // Clock
  input wire logic                             rst_n_i,         // Reset
  input wire logic                             rst_pin_n_i,     // Pin
  input wire logic [rcs_pkg::RCS_FOSC_NUM-1:0] fast_tick_i,     // Fast
  input wire logic                             slow_tick_i,     // Slow
  input wire logic                             avs_read,        // Read
  input wire logic                             avs_write,       // Write
  input wire logic                             avs_waitrequest, // Stall
  input wire logic                             sys_rst_n_o,     // Core
  input wire logic                             sys_init_o,      // Init
  input wire logic                             core_clk_en_o,   // Clock
  input wire logic                             exec_start_o,    // Start
  input wire logic [rcs_pkg::RCS_PC_W-1:0]     start_addr_o,    // Vector
  input wire logic                             cpu_tick_o       // Tick
);
  import rcs_pkg::*;

  // ------------------------------------------------------------
  // Sequence checks
  // ------------------------------------------------------------
  logic        any_tick;
  logic [15:0] warm_cnt;

  assign any_tick = slow_tick_i | (|fast_tick_i);

  // The count restarts on each init pulse, so it measures warm-up alone.
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      warm_cnt <= '0;
    else if (sys_init_o)
      warm_cnt <= '0;
    else
      warm_cnt <= warm_cnt + 16'h1;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_clk_gate_rst:
    assert property (sys_rst_n_o |-> core_clk_en_o)
    else $error("core reset released without clock");
  a_start_vector:
    assert property (exec_start_o |-> start_addr_o == RCS_RESET_VECTOR)
    else $error("start address not zero");
  a_start_rise:
    assert property (exec_start_o == $rose(core_clk_en_o))
    else $error("start pulse not aligned with clock enable");
  a_exec_pulse:
    assert property (exec_start_o |=> (!exec_start_o) [*8])
    else $error("start pulse repeated");
  a_init_first:
    assert property (sys_init_o |=> !sys_init_o && !core_clk_en_o)
    else $error("init pulse malformed");
  a_warm_len:
    assert property ($rose(core_clk_en_o) |->
      warm_cnt >= WARMUP_CYCLES - 2 && warm_cnt <= WARMUP_CYCLES + 2)
    else $error("warm-up length wrong");
  a_tick_cause:
    assert property (cpu_tick_o |-> $past(any_tick))
    else $error("instruction tick without source tick");
  a_rst_cause:
    assert property ($fell(sys_rst_n_o) |-> !rst_pin_n_i || !core_clk_en_o)
    else $error("core reset fell without cause");
  a_one_wait:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
endmodule : rcs_checker

bind rcs_sequencer rcs_checker #(
  .WARMUP_CYCLES(WARMUP_CYCLES),
  .WDT_TICKS(WDT_TICKS)
) u_rcs_checker (
  .clk_i, .rst_n_i, .rst_pin_n_i, .fast_tick_i, .slow_tick_i,
  .avs_read, .avs_write, .avs_waitrequest, .sys_rst_n_o, .sys_init_o,
  .core_clk_en_o, .exec_start_o, .start_addr_o, .cpu_tick_o
);

// ===== verif/rcs_pin_driver.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Board reset supervisor
// ------------------------------------------------------------
module rcs_pin_driver (
  input  wire logic       clk_i,       // Clock
  input  wire logic       press_i,     // Hold reset
  input  wire logic [7:0] hold_cyc_i,  // Release delay
  output logic            rst_pin_n_o  // Reset pin
);
  logic [7:0] cnt;

  initial
  begin
    cnt         = 8'h00;
    rst_pin_n_o = 1'b0;
  end

  always @(posedge clk_i)
    if (press_i)
    begin
      cnt         <= hold_cyc_i;
      rst_pin_n_o <= 1'b0;
    end
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
    else
      rst_pin_n_o <= 1'b1;
endmodule : rcs_pin_driver

// ===== verif/test_rcs_sequencer.sv
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      fail_count++; \
      $display("BAD %0t got %0h want %0h", $time, (a), (b)); \
    end \
  end

module test_rcs_sequencer;
  import rcs_pkg::*;
  localparam int WU = 8;
  localparam int WT = 1000;

  // ------------------------------------------------------------
  // Bench signals
  // ------------------------------------------------------------
  logic                    clk_i, rst_n_i, rst_pin_n_i, power_good_i;
  logic [RCS_FOSC_NUM-1:0] fast_tick_i;
  logic                    slow_tick_i, avs_read, avs_write, press;
  logic [3:0]              avs_address;
  logic [31:0]             avs_writedata, avs_readdata, q;
  logic                    avs_waitrequest, sys_rst_n_o, sys_init_o;
  logic                    core_clk_en_o, exec_start_o, cpu_tick_o;
  logic [RCS_PC_W-1:0]     start_addr_o;
  logic [7:0]              hold;
  int                      fail_count, total_checks, n, tcnt;

  rcs_sequencer #(.WARMUP_CYCLES(WU), .WDT_TICKS(WT)) u_rcs_sequencer (
    .clk_i, .rst_n_i, .rst_pin_n_i, .power_good_i, .fast_tick_i,
    .slow_tick_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .sys_rst_n_o,
    .sys_init_o, .core_clk_en_o, .exec_start_o, .start_addr_o, .cpu_tick_o
  );
  rcs_pin_driver u_rcs_pin_driver (
    .clk_i, .press_i(press), .hold_cyc_i(hold), .rst_pin_n_o(rst_pin_n_i)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Source k ticks every k+2 cycles, the slow source every 5.
  always @(posedge clk_i)
  begin
    tcnt <= tcnt + 1;
    for (int k = 0; k < RCS_FOSC_NUM; k++)
      fast_tick_i[k] <= (tcnt % (k + 2)) == 0;
    slow_tick_i <= (tcnt % 5) == 0;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic lim(input logic ok);
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      print_verdict();
    end
  endtask : lim

  function automatic logic pick(input int w);
    case (w)
      0: pick = core_clk_en_o;
      1: pick = exec_start_o;
      2: pick = sys_init_o;
      3: pick = !core_clk_en_o;
      default: pick = cpu_tick_o;
    endcase
  endfunction : pick

  task automatic wait_for(input int w, input int m);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (pick(w) !== 1'b1 && n < m);
    lim(pick(w));
  endtask : wait_for

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge clk_i);
    n = 0;
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clk_i);
      n++;
    end
    lim(avs_waitrequest === 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic gap(input logic [31:0] c, input int e);
    wr(RCS_WDT_CLR_ADDR, 32'h1);
    wr(RCS_CTRL_ADDR, c);
    repeat (3) wait_for(4, 800);
    `CHK(n, e)
  endtask : gap

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd(RCS_CTRL_ADDR);
    `CHK(q, 32'h0000_0001)
    rd(RCS_STATUS_ADDR);
    `CHK({q[5:2], q[1:0]}, 6'h10)
    wr(4'hc, 32'hffff_ffff);
    rd(4'hc);
    `CHK(q, 32'h0)
    $display("register test done");
  endtask : t_regs

  task automatic t_boot;
    repeat (20) @(posedge clk_i);
    `CHK({core_clk_en_o, sys_rst_n_o}, 2'b00)
    hold  <= 8'h03;
    @(posedge clk_i);
    press <= 1'b0;
    wait_for(2, 30);
    wait_for(1, WU + 10);
    `CHK(start_addr_o, RCS_RESET_VECTOR)
    `CHK({core_clk_en_o, sys_rst_n_o}, 2'b11)
    $display("boot test done");
  endtask : t_boot

  task automatic t_pin;
    hold  <= 8'h00;
    press <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK({core_clk_en_o, sys_rst_n_o}, 2'b10)
    wait_for(3, 10);
    press <= 1'b0;
    wait_for(0, WU + 20);
    rd(RCS_STATUS_ADDR);
    `CHK(q[RCS_STAT_CAUSE_PIN_BIT], 1'b1)
    wr(RCS_CTRL_ADDR, 32'h0);
    press <= 1'b1;
    repeat (12) @(posedge clk_i);
    `CHK({core_clk_en_o, sys_rst_n_o}, 2'b11)
    press <= 1'b0;
    repeat (3) @(posedge clk_i);
    wr(RCS_CTRL_ADDR, 32'h1);
    $display("pin test done");
  endtask : t_pin

  task automatic t_div;
    for (int k = 0; k < RCS_FOSC_NUM; k++)
      gap({21'h0, 3'(k), 3'h0, 3'(k), 2'b01}, (k + 2) << k);
    gap(32'h0000_001d, 256);
    for (int s = 0; s < 4; s++)
      gap({25'h0, 2'(s), 3'h0, 2'b11}, 5 << s);
    rd(RCS_STATUS_ADDR);
    `CHK(q[RCS_STAT_SLOW_BIT], 1'b1)
    wr(RCS_CTRL_ADDR, 32'h1);
    $display("divider test done");
  endtask : t_div

  task automatic t_wdt;
    repeat (2)
    begin
      wr(RCS_WDT_CLR_ADDR, 32'h1);
      repeat (WT * 4) @(posedge clk_i);
    end
    `CHK(core_clk_en_o, 1'b1)
    rd(RCS_STATUS_ADDR);
    `CHK(q[RCS_STAT_CAUSE_WDT_BIT], 1'b0)
    power_good_i <= 1'b0;
    wait_for(3, WT * 6);
    repeat (50) @(posedge clk_i);
    `CHK(core_clk_en_o, 1'b0)
    power_good_i <= 1'b1;
    wait_for(0, WU + 40);
    rd(RCS_STATUS_ADDR);
    `CHK(q[RCS_STAT_CAUSE_WDT_BIT], 1'b1)
    $display("watchdog test done");
  endtask : t_wdt

  initial
  begin
    fail_count    = 0;
    total_checks  = 0;
    tcnt          = 0;
    rst_n_i       = 1'b0;
    press         = 1'b1;
    hold          = 8'h00;
    power_good_i  = 1'b1;
    fast_tick_i   = '0;
    slow_tick_i   = 1'b0;
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_boot();
    t_pin();
    t_div();
    t_wdt();
    print_verdict();
  end
endmodule : test_rcs_sequencer
